// *** ssr_consts.svh ***
// Purpose: Register offsets, field positions and reset values
// Assumes: 32-bit APB, one aligned word per register
// Notes: Definitions only
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define SSR_OFF_CTRL 12'h000
`define SSR_OFF_TXH 12'h004
`define SSR_OFF_RXH 12'h008
`define SSR_OFF_RSH 12'h00c
`define SSR_OFF_TSH 12'h010
`define SSR_OFF_CMP0 12'h014
`define SSR_OFF_CMP1 12'h018
`define SSR_OFF_STAT 12'h01c
`define SSR_OFF_IEN 12'h020
`define SSR_OFF_IDIS 12'h024

// ==========================================================
// Register select codes
`define SSR_SEL_CTRL 4'h0
`define SSR_SEL_TXH 4'h1
`define SSR_SEL_RXH 4'h2
`define SSR_SEL_RSH 4'h3
`define SSR_SEL_TSH 4'h4
`define SSR_SEL_CMP0 4'h5
`define SSR_SEL_CMP1 4'h6
`define SSR_SEL_STAT 4'h7
`define SSR_SEL_IEN 4'h8
`define SSR_SEL_IDIS 4'h9
`define SSR_SEL_NONE 4'hf

// ==========================================================
// Control register fields
`define SSR_CTRL_TXON 0
`define SSR_CTRL_RXON 1
`define SSR_CTRL_WB_LO 4
`define SSR_CTRL_WB_HI 8
`define SSR_CTRL_SL_LO 12
`define SSR_CTRL_SL_HI 15
`define SSR_CTRL_PAYLOAD 16
`define SSR_CTRL_EDGE 17

// ==========================================================
// Status bit positions
`define SSR_ST_TX_FREE 0
`define SSR_ST_ALL_SENT 1
`define SSR_ST_TX_DONE 2
`define SSR_ST_TX_ZERO 3
`define SSR_ST_RX_AVAIL 4
`define SSR_ST_RX_OVER 5
`define SSR_ST_RX_DONE 6
`define SSR_ST_RX_ZERO 7
`define SSR_ST_CMP0 8
`define SSR_ST_CMP1 9
`define SSR_ST_TX_SYNC 10
`define SSR_ST_RX_SYNC 11

// ==========================================================
// Reset values
`define SSR_WBITS_RST 5'h07
`define SSR_FLAGS_RST 12'h000
`define SSR_MASK_RST 12'h000

`endif

// *** ssr_pkg.sv ***
// Purpose: Types shared by the serial status register block
// Assumes: Constants come from ssr_consts.svh
// Notes: Types only
package ssr_pkg;

   // ==========================================================
   // Transmit sequencer states
   typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_DATA} ssr_tx_e;

   // ==========================================================
   // APB request and answer
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ssr_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ssr_apb_rsp_s;

   // ==========================================================
   // Whole module state
   typedef struct packed {
      logic tx_on;
      logic rx_on;
      logic [4:0] wbits;
      logic [3:0] sync_len;
      logic payload_on;
      logic edge_sel;
      logic [31:0] holding;
      logic holding_full;
      logic [31:0] shifter;
      logic [15:0] sync_sh;
      logic [4:0] cnt;
      ssr_tx_e tx_st;
      logic [15:0] tx_sync_word;
      logic [15:0] cmp0;
      logic [15:0] cmp1;
      logic [31:0] rx_hold;
      logic rx_fresh;
      logic [15:0] rx_sync_word;
      logic [11:0] flags;
      logic [11:0] imask;
      logic [2:0] lk;
      logic [2:0] rf;
      logic tx_pin;
      logic fs_pin;
      logic fs_d;
      logic [31:0] prdata;
      logic pslverr;
   } ssr_state_s;

endpackage : ssr_pkg

// *** ssr_regs.sv ***
// Purpose: Serial controller status, holding and interrupt register set
// Assumes: APB slave on pclk, link clock sampled as a plain input
// Notes: Read data captured in setup phase, answered with no wait state
//
// How it works
// - Transmit holding word is write-only, 32 bits, taken right aligned.
// - Status bit 0 reads 0 while a written word waits, else 1.
// - Status bit 1 reads 1 once the last word fully left or its frame was abandoned.
// - Bit 2 sets when transmit count hits zero, clears on count write.
// - Bits 3 and 7 are 1 only when both counters are zero.
// - Bit 4 sets when a received word lands in the holding register.
// - Bit 5 sets on a load over an unread word, cleared by status read.
// - Bit 6 sets when receive count hits zero, clears on count write.
// - Bits 8 and 9 record compare matches; status read clears them.
// - Bits 10 and 11 record sync events; status read clears them.
// - Bits 16 and 17 show transmitter and receiver enabled.
// - Writing 1 to the enable register enables that source.
// - Writing 1 to the disable register disables that source.
// - Enable and disable bits match status bits 0 to 11.
// - Receive sync word reads in bits 15 to 0, upper bits zero.
// - Transmit sync word is read-write in bits 15 to 0.
// - Two read-write 16-bit compare values drive matches 0 and 1.
// - With payload on, sync word bits go out during the sync pulse.
// - Transmit sync event on rising edge for select 0, falling for 1.
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "ssr_consts.svh"

module ssr_regs
   import ssr_pkg::*;
(
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire ssr_apb_req_s apb_req, // APB request from master
   output ssr_apb_rsp_s apb_rsp, // APB answer
   input wire logic link_clk_pin, // Serial clock from the link
   input wire logic rx_frame_sync_pin, // Receive frame sync pin
   input wire logic rx_load, // Receiver delivers a word, pulse
   input wire logic [31:0] rx_word, // Received word, right aligned
   input wire logic rx_sync_load, // Receiver delivers sync data, pulse
   input wire logic [15:0] rx_sync_in, // Received sync data
   input wire logic tx_dma_count_zero, // Transmit count is zero
   input wire logic tx_dma_next_count_zero, // Transmit next count zero
   input wire logic tx_dma_count_written, // Transmit count write, pulse
   input wire logic rx_dma_count_zero, // Receive count is zero
   input wire logic rx_dma_next_count_zero, // Receive next count zero
   input wire logic rx_dma_count_written, // Receive count write, pulse
   output logic tx_data_pin, // Serial data out
   output logic tx_frame_sync_pin, // Transmit frame sync out
   output logic irq // Interrupt request, active high
);

   // ==========================================================
   // Address decode
   function automatic logic [3:0] reg_sel(input logic [11:0] a);
      logic [3:0] r;
      r = `SSR_SEL_NONE;
      case (a)
         `SSR_OFF_CTRL: r = `SSR_SEL_CTRL;
         `SSR_OFF_TXH: r = `SSR_SEL_TXH;
         `SSR_OFF_RXH: r = `SSR_SEL_RXH;
         `SSR_OFF_RSH: r = `SSR_SEL_RSH;
         `SSR_OFF_TSH: r = `SSR_SEL_TSH;
         `SSR_OFF_CMP0: r = `SSR_SEL_CMP0;
         `SSR_OFF_CMP1: r = `SSR_SEL_CMP1;
         `SSR_OFF_STAT: r = `SSR_SEL_STAT;
         `SSR_OFF_IEN: r = `SSR_SEL_IEN;
         `SSR_OFF_IDIS: r = `SSR_SEL_IDIS;
         default: r = `SSR_SEL_NONE;
      endcase
      return r;
   endfunction : reg_sel

   ssr_state_s s;
   ssr_state_s next_s;

   logic setup;
   logic access;
   logic [3:0] sel;
   logic [31:0] stat;
   logic [31:0] rd_val;
   logic link_fall;
   logic tx_sync_ev;
   logic rx_sync_ev;
   logic tx_all_sent;
   logic [11:0] ev;
   logic [11:0] clr;

   // ==========================================================
   // Bus phase and decode
   assign setup = apb_req.psel & ~apb_req.penable;
   assign access = apb_req.psel & apb_req.penable;
   assign sel = reg_sel(apb_req.paddr);

   // Link edges seen only behind the second sampling flop
   assign link_fall = s.lk[2] & ~s.lk[1];
   assign rx_sync_ev = s.edge_sel ? (s.rf[2] & ~s.rf[1])
                                  : (~s.rf[2] & s.rf[1]);
   assign tx_sync_ev = s.edge_sel ? (s.fs_d & ~s.fs_pin)
                                  : (~s.fs_d & s.fs_pin);

   // Nothing waiting and the shifter has finished its last bit or had its frame abandoned
   assign tx_all_sent = ~s.holding_full & (s.tx_st == TX_IDLE);

   // ==========================================================
   // Live status word; sticky bits come from the flag register
   always_comb
   begin
      stat = '0;
      stat[`SSR_ST_TX_FREE] = ~s.holding_full;
      stat[`SSR_ST_ALL_SENT] = tx_all_sent;
      stat[`SSR_ST_TX_DONE] = s.flags[`SSR_ST_TX_DONE];
      stat[`SSR_ST_TX_ZERO] = tx_dma_count_zero
                              & tx_dma_next_count_zero;
      stat[`SSR_ST_RX_AVAIL] = s.flags[`SSR_ST_RX_AVAIL];
      stat[`SSR_ST_RX_OVER] = s.flags[`SSR_ST_RX_OVER];
      stat[`SSR_ST_RX_DONE] = s.flags[`SSR_ST_RX_DONE];
      stat[`SSR_ST_RX_ZERO] = rx_dma_count_zero
                              & rx_dma_next_count_zero;
      stat[11:8] = s.flags[11:8];
      stat[16] = s.tx_on;
      stat[17] = s.rx_on;
   end

   // ==========================================================
   // Read mux; reserved bits read as zero
   always_comb
   begin
      rd_val = '0;
      case (sel)
         `SSR_SEL_CTRL: rd_val = {14'h0, s.edge_sel, s.payload_on,
                                  s.sync_len, 3'h0, s.wbits, 2'h0,
                                  s.rx_on, s.tx_on};
         `SSR_SEL_RXH: rd_val = s.rx_hold;
         `SSR_SEL_RSH: rd_val = {16'h0, s.rx_sync_word};
         `SSR_SEL_TSH: rd_val = {16'h0, s.tx_sync_word};
         `SSR_SEL_CMP0: rd_val = {16'h0, s.cmp0};
         `SSR_SEL_CMP1: rd_val = {16'h0, s.cmp1};
         `SSR_SEL_STAT: rd_val = stat;
         default: rd_val = '0; // Write-only and unmapped read zero
      endcase
   end

   // ==========================================================
   // Sticky flag events and clears
   always_comb
   begin
      ev = `SSR_FLAGS_RST;
      clr = `SSR_FLAGS_RST;
      ev[`SSR_ST_TX_DONE] = tx_dma_count_zero;
      ev[`SSR_ST_RX_AVAIL] = rx_load;
      ev[`SSR_ST_RX_DONE] = rx_dma_count_zero;
      ev[`SSR_ST_CMP0] = rx_load & (rx_word[15:0] == s.cmp0);
      ev[`SSR_ST_CMP1] = rx_load & (rx_word[15:0] == s.cmp1);
      ev[`SSR_ST_TX_SYNC] = tx_sync_ev;
      ev[`SSR_ST_RX_SYNC] = rx_sync_ev;
      clr[`SSR_ST_TX_DONE] = tx_dma_count_written;
      clr[`SSR_ST_RX_DONE] = rx_dma_count_written;
      // Holding read drops ready unless a newer word arrived since
      if (access && !apb_req.pwrite && sel == `SSR_SEL_RXH)
         clr[`SSR_ST_RX_AVAIL] = ~s.rx_fresh;
      // Status read clears only the bits the reader actually saw
      if (access && !apb_req.pwrite && sel == `SSR_SEL_STAT)
      begin
         clr[`SSR_ST_RX_OVER] = s.prdata[`SSR_ST_RX_OVER];
         clr[11:8] = s.prdata[11:8];
      end
      // A load onto an unread word that is not being read now
      ev[`SSR_ST_RX_OVER] = rx_load & s.flags[`SSR_ST_RX_AVAIL]
                            & ~clr[`SSR_ST_RX_AVAIL];
   end

   // ==========================================================
   // Next state
   always_comb
   begin
      next_s = s;

      // Two flops on each pin before anything looks at it
      next_s.lk = {s.lk[1:0], link_clk_pin};
      next_s.rf = {s.rf[1:0], rx_frame_sync_pin};
      next_s.fs_d = s.fs_pin;

      // Set wins over clear so no event is lost
      next_s.flags = (s.flags & ~clr) | ev;

      // Receive side captures
      if (rx_load)
      begin
         next_s.rx_hold = rx_word;
         next_s.rx_fresh = 1'b1;
      end
      if (rx_sync_load)
         next_s.rx_sync_word = rx_sync_in;

      // Transmit sequencer, one bit per falling link edge
      if (link_fall)
      begin
         case (s.tx_st)
            TX_IDLE:
            begin
               next_s.tx_pin = 1'b0;
               if (s.tx_on && s.holding_full)
               begin
                  next_s.shifter = s.holding;
                  next_s.holding_full = 1'b0;
                  next_s.tx_st = TX_SYNC;
                  next_s.fs_pin = 1'b1;
                  next_s.cnt = {1'b0, s.sync_len};
                  next_s.sync_sh = s.tx_sync_word >> 1;
                  // Sync pulse carries the payload or the idle level
                  next_s.tx_pin = s.payload_on & s.tx_sync_word[0];
               end
            end
            TX_SYNC:
            begin
               if (s.cnt == 5'h00)
               begin
                  next_s.tx_st = TX_DATA;
                  next_s.fs_pin = 1'b0;
                  next_s.cnt = s.wbits;
                  next_s.tx_pin = s.shifter[0];
                  next_s.shifter = s.shifter >> 1;
               end
               else
               begin
                  next_s.cnt = s.cnt - 5'h01;
                  next_s.tx_pin = s.payload_on & s.sync_sh[0];
                  next_s.sync_sh = s.sync_sh >> 1;
               end
            end
            TX_DATA:
            begin
               if (s.cnt == 5'h00)
               begin
                  // Costs one idle link period between frames
                  next_s.tx_st = TX_IDLE;
                  next_s.tx_pin = 1'b0;
               end
               else
               begin
                  next_s.cnt = s.cnt - 5'h01;
                  next_s.tx_pin = s.shifter[0];
                  next_s.shifter = s.shifter >> 1;
               end
            end
            default:
            begin
               next_s.tx_st = TX_IDLE;
               next_s.fs_pin = 1'b0;
            end
         endcase
      end

      // Disabling the transmitter abandons the frame at once
      if (!s.tx_on)
      begin
         next_s.tx_st = TX_IDLE;
         next_s.fs_pin = 1'b0;
         next_s.tx_pin = 1'b0;
      end

      // Setup phase: capture the answer so read effects match it
      if (setup)
      begin
         next_s.prdata = apb_req.pwrite ? 32'h0 : rd_val;
         next_s.pslverr = (sel == `SSR_SEL_NONE);
         if (!apb_req.pwrite && sel == `SSR_SEL_RXH)
            next_s.rx_fresh = rx_load;
      end

      // Access phase writes; read-only targets ignore them
      if (access && apb_req.pwrite)
      begin
         case (sel)
            `SSR_SEL_CTRL:
            begin
               next_s.tx_on = apb_req.pwdata[`SSR_CTRL_TXON];
               next_s.rx_on = apb_req.pwdata[`SSR_CTRL_RXON];
               next_s.wbits =
                  apb_req.pwdata[`SSR_CTRL_WB_HI:`SSR_CTRL_WB_LO];
               next_s.sync_len =
                  apb_req.pwdata[`SSR_CTRL_SL_HI:`SSR_CTRL_SL_LO];
               next_s.payload_on = apb_req.pwdata[`SSR_CTRL_PAYLOAD];
               next_s.edge_sel = apb_req.pwdata[`SSR_CTRL_EDGE];
            end
            `SSR_SEL_TXH:
            begin
               // Full word kept; the shifter sends the low bits
               next_s.holding = apb_req.pwdata;
               next_s.holding_full = 1'b1;
            end
            `SSR_SEL_TSH: next_s.tx_sync_word = apb_req.pwdata[15:0];
            `SSR_SEL_CMP0: next_s.cmp0 = apb_req.pwdata[15:0];
            `SSR_SEL_CMP1: next_s.cmp1 = apb_req.pwdata[15:0];
            `SSR_SEL_IEN:
               next_s.imask = s.imask | apb_req.pwdata[11:0];
            `SSR_SEL_IDIS:
               next_s.imask = s.imask & ~apb_req.pwdata[11:0];
            default: next_s.imask = next_s.imask;
         endcase
      end
   end

   // ==========================================================
   // State register; every source masked out at reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s <= '0;
         s.wbits <= `SSR_WBITS_RST;
         s.flags <= `SSR_FLAGS_RST;
         s.imask <= `SSR_MASK_RST;
      end
      else
         s <= next_s;
   end

   // ==========================================================
   // Outputs; zero wait state, answer held in flops
   assign apb_rsp.prdata = s.prdata;
   assign apb_rsp.pslverr = s.pslverr & apb_req.penable;
   assign apb_rsp.pready = apb_req.penable;
   assign tx_data_pin = s.tx_pin;
   assign tx_frame_sync_pin = s.fs_pin;
   assign irq = |(stat[11:0] & s.imask);

endmodule : ssr_regs

// *** ssr_chk.sv ***
// Purpose: Assertions on the serial status register block
// Assumes: Sees only top ports; shadows follow APB writes, rsh the sync word strobe
// Notes: Bound into ssr_regs at the foot of this file
`timescale 1ns/1ps
`include "ssr_consts.svh"

module ssr_chk
   import ssr_pkg::*;
(
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, active low
   input wire ssr_apb_req_s apb_req, // APB request
   input wire ssr_apb_rsp_s apb_rsp, // APB answer
   input wire logic rx_sync_load, // Sync word strobe
   input wire logic [15:0] rx_sync_in, // Sync word
   input wire logic tx_dma_count_zero, // Tx count zero
   input wire logic tx_dma_next_count_zero, // Tx next zero
   input wire logic rx_dma_count_zero, // Rx count zero
   input wire logic rx_dma_next_count_zero, // Rx next zero
   input wire logic irq // Interrupt out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr;
   logic rd;
   logic [11:0] a;
   logic [31:0] q;
   logic [31:0] d;
   logic [3:0] z;
   logic [11:0] msk;
   logic [1:0] ctl;
   logic [15:0] tsh;
   logic [15:0] c0;
   logic [15:0] c1;
   logic [15:0] rsh;

   // ==========
   // Access decode
   assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign rd = apb_req.psel & apb_req.penable & !apb_req.pwrite;
   assign a = apb_req.paddr;
   assign q = apb_rsp.prdata;
   assign d = apb_req.pwdata;
   assign z = {rx_dma_next_count_zero, rx_dma_count_zero,
      tx_dma_next_count_zero, tx_dma_count_zero};

   // Shadows move on the same edge as the block, so no lag to allow for
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         msk <= 12'h000;
         ctl <= 2'h0;
         tsh <= 16'h0000;
         c0 <= 16'h0000;
         c1 <= 16'h0000;
         rsh <= 16'h0000;
      end
      else
      begin
         if (wr && a == `SSR_OFF_IEN)
            msk <= msk | d[11:0];
         if (wr && a == `SSR_OFF_IDIS)
            msk <= msk & ~d[11:0];
         if (wr && a == `SSR_OFF_CTRL)
            ctl <= d[1:0];
         if (wr && a == `SSR_OFF_TSH)
            tsh <= d[15:0];
         if (wr && a == `SSR_OFF_CMP0)
            c0 <= d[15:0];
         if (wr && a == `SSR_OFF_CMP1)
            c1 <= d[15:0];
         if (rx_sync_load)
            rsh <= rx_sync_in;
      end
   end

   // ==========
   // Properties
   property p_irq_off;
      msk == 12'h000 |-> !irq;
   endproperty
   a_irq_off: assert property (p_irq_off)
      else $error("irq raised with every source off");
   property p_irq_mask;
      rd && a == `SSR_OFF_STAT |-> $past(irq) == |(q[11:0] & msk);
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("irq disagrees with status and mask");
   property p_transmitter_on;
      rd && a == `SSR_OFF_STAT |-> q[17:16] == ctl;
   endproperty
   a_transmitter_on: assert property (p_transmitter_on)
      else $error("enable bits disagree with control");
   property p_tsync;
      rd && a == `SSR_OFF_TSH |-> q[15:0] == tsh;
   endproperty
   a_tsync: assert property (p_tsync)
      else $error("tx sync word readback wrong");
   property p_cmp;
      rd && (a == `SSR_OFF_CMP0 || a == `SSR_OFF_CMP1)
         |-> q[15:0] == (a == `SSR_OFF_CMP0 ? c0 : c1);
   endproperty
   a_cmp: assert property (p_cmp)
      else $error("compare value readback wrong");
   property p_rsync;
      rd && a == `SSR_OFF_RSH |-> q == {16'h0000, rsh};
   endproperty
   a_rsync: assert property (p_rsync)
      else $error("rx sync word readback wrong");
   property p_wo;
      rd && (a == `SSR_OFF_TXH || a == `SSR_OFF_IEN || a == `SSR_OFF_IDIS)
         |-> q == 32'h0;
   endproperty
   a_wo: assert property (p_wo)
      else $error("write-only register read nonzero");
   property p_zero;
      rd && a == `SSR_OFF_STAT && $past(z) == z && $past(z, 2) == z
         |-> q[3] == &z[1:0] && q[7] == &z[3:2];
   endproperty
   a_zero: assert property (p_zero)
      else $error("counter zero bits wrong");
endmodule : ssr_chk

bind ssr_regs ssr_chk u_chk (.pclk, .presetn, .apb_req, .apb_rsp,
   .rx_sync_load, .rx_sync_in, .tx_dma_count_zero, .tx_dma_next_count_zero,
   .rx_dma_count_zero, .rx_dma_next_count_zero, .irq);

// *** ssr_peer.sv ***
// Purpose: Serial peer that clocks the link and captures one frame
// Assumes: Block launches bits on the link falling edge
// Notes: Clock stands still low outside frames
`timescale 1ns/1ps

module ssr_peer
(
   input wire logic run, // Clock the link while high
   input wire logic tx_data_pin, // Serial data from block
   input wire logic tx_frame_sync_pin, // Frame sync from block
   output logic link_clk_pin, // Link clock, 160 ns
   output logic [15:0] got_sync, // Bits seen under sync
   output logic [31:0] got_word // Bits seen after sync
);
   int ns;
   int nb;

   // ==========
   // Link clock, offset so its edges never meet pclk edges
   initial
   begin
      link_clk_pin = 1'b0;
      #7;
      forever
      begin
         #80;
         if (run || link_clk_pin)
            link_clk_pin = ~link_clk_pin;
      end
   end

   // New frame clears the capture
   always @(posedge run)
   begin
      ns = 0;
      nb = 0;
      got_sync = 16'h0000;
      got_word = 32'h0;
   end

   // Sample at the next fall, a full period after launch
   always @(negedge link_clk_pin)
   begin
      if (tx_frame_sync_pin && ns < 16)
      begin
         got_sync[ns] = tx_data_pin;
         ns++;
      end
      else if (ns > 0 && nb < 32)
      begin
         got_word[nb] = tx_data_pin;
         nb++;
      end
   end
endmodule : ssr_peer

// *** tb_top.sv ***
// Purpose: Self-checking bench for the serial status register block
// Assumes: Zero-wait APB slave, link clock from the peer model
// Notes: One task per scenario
`timescale 1ns/1ps
`include "ssr_consts.svh"
`define CHK(n, e, g) \
   begin \
      num_checks++; \
      if ((g) !== (e)) \
      begin \
         fails++; \
         $display("wrong value %s exp %h got %h", n, e, g); \
      end \
   end

module tb_top import ssr_pkg::*;;
   logic pclk;
   logic presetn = 1'b0;
   ssr_apb_req_s apb_req = '0;
   ssr_apb_rsp_s apb_rsp;
   logic link_clk_pin;
   logic rx_frame_sync_pin = 1'b0;
   logic rx_load = 1'b0;
   logic [31:0] rx_word = 32'h0;
   logic rx_sync_load = 1'b0;
   logic [15:0] rx_sync_in = 16'h0000;
   logic [1:0] dz = 2'b00;
   logic [1:0] dnz = 2'b00;
   logic [1:0] dw = 2'b00;
   logic tx_data_pin;
   logic tx_frame_sync_pin;
   logic irq;
   logic run = 1'b0;
   logic [31:0] q;
   logic e;
   logic [15:0] gs;
   logic [31:0] gw;
   int fails = 0;
   int num_checks = 0;
   int cyc = 0;
   localparam logic [11:0] irq_addr [5] = '{`SSR_OFF_IEN, `SSR_OFF_IEN,
      `SSR_OFF_IEN, `SSR_OFF_IDIS, `SSR_OFF_IDIS};
   localparam logic [31:0] irq_data [5] = '{32'hfffff000, 32'h10, 32'h0,
      32'h0, 32'h10};
   localparam logic [4:0] irq_exp = 5'b01110;

   ssr_regs uut (.pclk, .presetn, .apb_req, .apb_rsp, .link_clk_pin,
      .rx_frame_sync_pin, .rx_load, .rx_word, .rx_sync_load, .rx_sync_in,
      .tx_dma_count_zero(dz[0]), .tx_dma_next_count_zero(dnz[0]),
      .tx_dma_count_written(dw[0]), .rx_dma_count_zero(dz[1]),
      .rx_dma_next_count_zero(dnz[1]), .rx_dma_count_written(dw[1]),
      .tx_data_pin, .tx_frame_sync_pin, .irq);
   ssr_peer peer (.run, .tx_data_pin, .tx_frame_sync_pin, .link_clk_pin,
      .got_sync(gs), .got_word(gw));

   // ==========
   // Clock and hang guard
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         end_of_test;
      end
   end

   // ==========
   // Bus and stimulus helpers; pl loads a word during the access cycle
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic pl = 1'b0);
      @(posedge pclk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      rx_load <= pl;
      // Only the bench timeout ends a wait that never completes
      do
         @(posedge pclk);
      while (apb_rsp.pready !== 1'b1);
      q = apb_rsp.prdata;
      e = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      rx_load <= 1'b0;
   endtask : apb
   task automatic ld(input logic [31:0] w);
      @(posedge pclk);
      rx_word <= w;
      rx_load <= 1'b1;
      @(posedge pclk);
      rx_load <= 1'b0;
   endtask : ld
   task end_of_test;
      if (fails == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_of_test

   // ==========
   // Scenarios
   task t_reset;
      apb(1'b0, `SSR_OFF_STAT, 32'h0);
      `CHK("tx free", 1'b1, q[0])
      `CHK("irq", 1'b0, irq)
      // Last pass hits the unmapped word after the disable register
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, i ? 12'h01c + 12'(4 * i) : `SSR_OFF_TXH, 32'h0);
         `CHK("write-only", 32'h0, q)
         `CHK("slave error", 1'(i == 3), e)
      end
   endtask : t_reset
   task t_regs;
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b1, `SSR_OFF_TSH + 12'(4 * i), {16'hdead, 16'h567a + 16'(i)});
         apb(1'b0, `SSR_OFF_TSH + 12'(4 * i), 32'h0);
         `CHK("sync or cmp", 16'h567a + 16'(i), q[15:0])
      end
      apb(1'b1, `SSR_OFF_RSH, 32'hffffffff);
      rx_sync_in <= 16'ha5c3;
      rx_sync_load <= 1'b1;
      @(posedge pclk);
      rx_sync_load <= 1'b0;
      apb(1'b0, `SSR_OFF_RSH, 32'h0);
      `CHK("rx sync", 32'h0000a5c3, q)
   endtask : t_regs
   // Done bits must hold after the count leaves zero, until rewritten
   task t_dma;
      for (int i = 0; i < 2; i++)
      begin
         @(posedge pclk);
         dz[i] <= 1'b1;
         apb(1'b0, `SSR_OFF_STAT, 32'h0);
         `CHK("zero", 1'b0, q[4 * i + 3])
         `CHK("done", 1'b1, q[4 * i + 2])
         dnz[i] <= 1'b1;
         apb(1'b0, `SSR_OFF_STAT, 32'h0);
         `CHK("zero", 1'b1, q[4 * i + 3])
         dz[i] <= 1'b0;
         apb(1'b0, `SSR_OFF_STAT, 32'h0);
         `CHK("done held", 1'b1, q[4 * i + 2])
         dw[i] <= 1'b1;
         @(posedge pclk);
         dw[i] <= 1'b0;
         apb(1'b0, `SSR_OFF_STAT, 32'h0);
         `CHK("done clear", 1'b0, q[4 * i + 2])
      end
   endtask : t_dma
   task t_rx;
      ld(32'hffff567b);
      apb(1'b0, `SSR_OFF_STAT, 32'h0);
      `CHK("rx flags", 6'b010001, q[9:4])
      apb(1'b0, `SSR_OFF_RXH, 32'h0);
      `CHK("rx word", 32'hffff567b, q)
      apb(1'b0, `SSR_OFF_STAT, 32'h0);
      `CHK("rx flags", 6'b000000, q[9:4])
      ld(32'h0000567c);
      ld(32'h0000567c);
      rx_word <= 32'h0;
      apb(1'b0, `SSR_OFF_STAT, 32'h0, 1'b1);
      `CHK("rx flags", 6'b100011, q[9:4])
      apb(1'b0, `SSR_OFF_STAT, 32'h0);
      `CHK("rx flags", 6'b000011, q[9:4])
      apb(1'b0, `SSR_OFF_RXH, 32'h0);
      apb(1'b0, `SSR_OFF_STAT, 32'h0);
      `CHK("rx flags", 6'b000000, q[9:4])
   endtask : t_rx
   task t_irq;
      ld(32'h0);
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b1, irq_addr[i], irq_data[i]);
         apb(1'b0, `SSR_OFF_STAT, 32'h0);
         @(negedge pclk);
         `CHK("irq", irq_exp[i], irq)
      end
   endtask : t_irq
   // Link held still until the word waits, so busy flags are seen
   // Second pass selects the falling sync edge; rise must not count
   task t_tx;
      for (int i = 0; i < 2; i++)
      begin
         apb(1'b1, `SSR_OFF_CTRL, {14'h0, i[0], 17'h13073});
         apb(1'b1, `SSR_OFF_TXH, 32'h5a5a5ac6);
         apb(1'b0, `SSR_OFF_STAT, 32'h0);
         `CHK("tx busy", 2'b00, q[1:0])
         `CHK("enables", 2'b11, q[17:16])
         rx_frame_sync_pin <= 1'b1;
         repeat (8) @(posedge pclk);
         apb(1'b0, `SSR_OFF_STAT, 32'h0);
         `CHK("rise event", 1'(1 - i), q[11])
         rx_frame_sync_pin <= 1'b0;
         run <= 1'b1;
         repeat (160) @(posedge pclk);
         run <= 1'b0;
         apb(1'b0, `SSR_OFF_STAT, 32'h0);
         `CHK("tx idle", 2'b11, q[1:0])
         `CHK("sync events", 2'(2 * i + 1), q[11:10])
         apb(1'b0, `SSR_OFF_STAT, 32'h0);
         `CHK("sync events", 2'b00, q[11:10])
         `CHK("sync bits", 4'ha, gs[3:0])
         `CHK("tx word", 32'h000000c6, gw)
      end
   endtask : t_tx

   // ==========
   // Main sequence
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_regs;
      t_dma;
      t_rx;
      t_irq;
      t_tx;
      end_of_test;
   end
endmodule : tb_top
